/* inc/hof_pkg.sv */
package hof_pkg;
	// ****************************************
	// array shape and timing
	// ****************************************
	localparam int NVAR = 4;
	localparam int BANKS = 7;
	localparam int MEM_DEPTH = 19;
	localparam int CLK_NS = 20;
	localparam int BX_NS = 150;
	localparam int BX_CYC = (BX_NS + CLK_NS - 1) / CLK_NS;
	localparam int MONO_SHORT_NS = 200;
	localparam int MONO_LONG_NS = 600;
	localparam int MONO_SHORT_CYC = MONO_SHORT_NS / CLK_NS;
	localparam int MONO_LONG_CYC = MONO_LONG_NS / CLK_NS;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] ISTAT_OFS = 8'h08;
	localparam logic [7:0] IMASK_OFS = 8'h0C;
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_INIT_BIT = 1;
	localparam int STAT_FORCE_BIT = 4;
	localparam int STAT_DONE_BIT = 5;
	localparam int IRQ_DONE_BIT = 4;
	localparam int IRQ_W = 5;
	localparam logic CTRL_RUN_RST = 1'b0;
	localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;

	typedef enum {RD_IDLE, RD_RUN, RD_DONE} rd_st_e;

	// bank select walks a gray sequence, one bit per step
	function automatic logic [2:0] gray3(input logic [2:0] b);
		return b ^ (b >> 1);
	endfunction : gray3
endpackage : hof_pkg

/* inc/row_bus_if.sv */
`timescale 1ns/1ps
interface row_bus_if;
	logic step;
	logic init;
	logic force_hit;
	logic [2:0] bank;
	modport drv (output step, output init, output force_hit, output bank);
	modport row (input step, input init, input force_hit, input bank);
endinterface : row_bus_if

/* rtl/row_ctl.sv */
`timescale 1ns/1ps
module row_ctl #(
	parameter int PW = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// shared row control
	row_bus_if.row ctl,
	// pixel hits of the selected bank
	input wire logic [PW-1:0] hit_pat,
	// readout
	input wire logic [4:0] rd_idx,
	output logic [4:0] cnt,
	output logic full,
	output logic [PW+2:0] rd_data
);
	import hof_pkg::*;

	logic [PW+2:0] mem [MEM_DEPTH];
	logic [4:0] cnt_r;

	wire bank_hit = ctl.force_hit | (|hit_pat);
	wire store = ctl.step & bank_hit & ~full & ~ctl.init;

	assign full = cnt_r == 5'(MEM_DEPTH);
	assign cnt = cnt_r;
	assign rd_data = (rd_idx < 5'(MEM_DEPTH)) ? mem[rd_idx] : '0;

	always_ff @(posedge clk) begin
		if (!rst_b || ctl.init) begin
			cnt_r <= 5'h00;
		end else if (store) begin
			cnt_r <= cnt_r + 5'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (store) begin
			mem[cnt_r] <= {ctl.bank, hit_pat};
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_force_stores: assert property (
		ctl.step && ctl.force_hit && !full && !ctl.init
		|=> cnt == $past(cnt) + 5'h01)
		else $error("forced bank not stored");
	a_idle_no_store: assert property (
		ctl.step && !ctl.force_hit && hit_pat == '0 && !ctl.init
		|=> cnt == $past(cnt))
		else $error("bank without hit was stored");
	a_store_pattern: assert property (
		store |=> mem[$past(cnt)] == $past({ctl.bank, hit_pat}))
		else $error("stored pattern differs from pixel hits");
	a_full_frozen: assert property (
		full && !ctl.init |=> full && mem[0] == $past(mem[0]))
		else $error("full row changed its memory");
	a_init_clears: assert property (
		ctl.init |=> cnt == 5'h00)
		else $error("init did not clear row");
endmodule : row_ctl

/* rtl/mono_pair.sv */
`timescale 1ns/1ps
module mono_pair #(
	parameter int SHORT_CYC = 10,
	parameter int LONG_CYC = 30
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// stimulus and pulses
	input wire logic trig,
	output logic short_p,
	output logic long_p
);
	if (SHORT_CYC < 8 || LONG_CYC < SHORT_CYC || LONG_CYC > 255) begin : g_bad
		$error("mono_pair: pulse lengths out of range");
	end

	logic trig_d_r;
	logic [7:0] s_cnt_r;
	logic [7:0] l_cnt_r;

	// comparator is not wired in: only the debug input fires
	wire fire = trig & ~trig_d_r;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			trig_d_r <= 1'b0;
			s_cnt_r <= 8'h00;
			l_cnt_r <= 8'h00;
		end else begin
			trig_d_r <= trig;
			s_cnt_r <= fire ? 8'(SHORT_CYC) : s_cnt_r - {7'h00, |s_cnt_r};
			l_cnt_r <= fire ? 8'(LONG_CYC) : l_cnt_r - {7'h00, |l_cnt_r};
		end
	end

	assign short_p = |s_cnt_r;
	assign long_p = |l_cnt_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_mono_start: assert property (
		fire |=> short_p && long_p)
		else $error("monostables not fired by stimulus");
	a_short_width: assert property (
		fire |=> short_p [*8])
		else $error("short pulse too brief");
endmodule : mono_pair

/* rtl/hit_test_top.sv */
`timescale 1ns/1ps
module hit_test_top #(
	parameter int NROWS = 4,
	parameter int PW = 4
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_B,
	// ahb-lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic [31:0] HRDATA,
	output logic HRESP,
	output logic IRQ,
	// pixel hits and override
	input wire logic [hof_pkg::NVAR*NROWS*PW-1:0] PIX_HIT,
	input wire logic HIT_FORCE_CTL,
	// readout
	input wire logic READ_EN,
	input wire logic [1:0] COL_SEL,
	output logic RD_VALID,
	output logic [$clog2(NROWS+1)+2+PW:0] RD_DATA,
	output logic ONWARD_READ_ENABLE,
	// full flags
	output logic FULL_FLAG_VARIANT_ONE,
	output logic FULL_FLAG_VARIANT_TWO,
	output logic FULL_FLAG_VARIANT_THREE,
	output logic FULL_FLAG_VARIANT_FOUR,
	// probes
	output logic PROBE_BANK_SEL_BIT0,
	output logic PROBE_ROW_RESET,
	output logic PROBE_PHASE_ONE,
	output logic PROBE_PHASE_TWO,
	output logic PROBE_PHASE_THREE,
	// monostable test pixel
	input wire logic TEST_HIT_STIMULUS,
	output logic PROBE_MONO_SHORT,
	output logic PROBE_MONO_LONG
);
	import hof_pkg::*;

	localparam int RW = $clog2(NROWS + 1);
	localparam int NR = NVAR * NROWS;
	localparam logic [RW-1:0] ROW_END = RW'(NROWS);

	if (NROWS < 1 || NROWS > 16 || PW < 1 || PW > 20 || BX_CYC < BANKS + 1
		|| BX_CYC > 15) begin : g_bad
		$error("hit_test_top: parameters out of range");
	end

	// ****************************************
	// seek first stored entry at or after (row, ent)
	// ****************************************
	function automatic logic [RW+4:0] seek(input logic [RW-1:0] row,
		input logic [4:0] ent, input logic [5*NROWS-1:0] cnts);
		logic [RW+4:0] res;
		logic got;
		logic [4:0] e0;
		res = {ROW_END, 5'h00};
		got = 1'b0;
		for (int r = 0; r < NROWS; r++) begin
			e0 = (RW'(r) == row) ? ent : 5'h00;
			if (!got && RW'(r) >= row && e0 < cnts[5*r+:5]) begin
				res = {RW'(r), e0};
				got = 1'b1;
			end
		end
		return res;
	endfunction : seek

	// ****************************************
	// bunch crossing sequencer
	// ****************************************
	row_bus_if rif();
	logic run_r;
	logic init_r;
	logic step_d_r;
	logic [3:0] bx_cnt_r;

	wire bx_last = bx_cnt_r == 4'(BX_CYC - 1);
	wire in_bank = bx_cnt_r < 4'(BANKS);

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B || !run_r) begin
			bx_cnt_r <= 4'h0;
		end else begin
			bx_cnt_r <= bx_last ? 4'h0 : bx_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		step_d_r <= RST_B & rif.step;
	end

	assign rif.step = run_r & in_bank;
	assign rif.bank = gray3(bx_cnt_r[2:0]);
	assign rif.force_hit = HIT_FORCE_CTL;
	assign rif.init = init_r;

	// ****************************************
	// row controllers
	// ****************************************
	logic [4:0] cnt_a [NR];
	logic [NR-1:0] full_a;
	logic [PW+2:0] dat_a [NR];
	logic [NVAR-1:0] full_v;
	logic [4:0] ent_r;
	logic [RW-1:0] row_r;
	logic [1:0] col_r;
	logic [5*NROWS-1:0] col_cnt;
	logic [RW+4:0] cur;

	for (genvar i = 0; i < NR; i++) begin : g_row
		row_ctl #(.PW(PW)) u_row (
			.clk(CLK_SYS),
			.rst_b(RST_B),
			.ctl(rif),
			.hit_pat(PIX_HIT[i*PW+:PW]),
			.rd_idx(cur[4:0]),
			.cnt(cnt_a[i]),
			.full(full_a[i]),
			.rd_data(dat_a[i])
		);
	end

	for (genvar v = 0; v < NVAR; v++) begin : g_var
		assign full_v[v] = |full_a[v*NROWS+:NROWS];
	end

	for (genvar r = 0; r < NROWS; r++) begin : g_col
		assign col_cnt[5*r+:5] = cnt_a[int'(col_r) * NROWS + r];
	end

	// ****************************************
	// readout walk
	// ****************************************
	rd_st_e rd_st_r;
	logic [NVAR-1:0] full_r;
	logic done_ev;

	assign cur = seek(row_r, ent_r, col_cnt);
	wire at_end = cur[RW+4:5] == ROW_END;
	wire [RW-1:0] cur_row = at_end ? '0 : cur[RW+4:5];
	wire [PW+2:0] cur_dat = dat_a[int'(col_r) * NROWS + int'(cur_row)];
	assign done_ev = rd_st_r == RD_RUN && READ_EN && at_end;

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			rd_st_r <= RD_IDLE;
			row_r <= '0;
			ent_r <= 5'h00;
			col_r <= 2'h0;
			RD_VALID <= 1'b0;
			RD_DATA <= '0;
			ONWARD_READ_ENABLE <= 1'b0;
		end else begin
			RD_VALID <= 1'b0;
			case (rd_st_r)
				RD_IDLE: begin
					ONWARD_READ_ENABLE <= 1'b0;
					row_r <= '0;
					ent_r <= 5'h00;
					if (READ_EN) begin
						col_r <= COL_SEL;
						rd_st_r <= RD_RUN;
					end
				end
				RD_RUN: begin
					if (!READ_EN) begin
						rd_st_r <= RD_IDLE;
					end else if (at_end) begin
						ONWARD_READ_ENABLE <= 1'b1;
						rd_st_r <= RD_DONE;
					end else begin
						RD_VALID <= 1'b1;
						RD_DATA <= {cur_row, cur_dat};
						row_r <= cur_row;
						ent_r <= cur[4:0] + 5'h01;
					end
				end
				RD_DONE: begin
					if (!READ_EN) begin
						ONWARD_READ_ENABLE <= 1'b0;
						rd_st_r <= RD_IDLE;
					end
				end
				default: rd_st_r <= RD_IDLE;
			endcase
		end
	end

	// ****************************************
	// flags and probes
	// ****************************************
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			full_r <= '0;
		end else begin
			full_r <= full_v;
		end
	end

	assign FULL_FLAG_VARIANT_ONE = full_r[0];
	assign FULL_FLAG_VARIANT_TWO = full_r[1];
	assign FULL_FLAG_VARIANT_THREE = full_r[2];
	assign FULL_FLAG_VARIANT_FOUR = full_r[3];

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			PROBE_BANK_SEL_BIT0 <= 1'b0;
			PROBE_ROW_RESET <= 1'b0;
			PROBE_PHASE_ONE <= 1'b0;
			PROBE_PHASE_TWO <= 1'b0;
			PROBE_PHASE_THREE <= 1'b0;
		end else begin
			PROBE_BANK_SEL_BIT0 <= rif.bank[0];
			PROBE_ROW_RESET <= init_r;
			PROBE_PHASE_ONE <= rif.step;
			PROBE_PHASE_TWO <= step_d_r;
			PROBE_PHASE_THREE <= run_r & (bx_cnt_r == 4'(BANKS));
		end
	end

	mono_pair #(.SHORT_CYC(MONO_SHORT_CYC), .LONG_CYC(MONO_LONG_CYC)) u_mono (
		.clk(CLK_SYS),
		.rst_b(RST_B),
		.trig(TEST_HIT_STIMULUS),
		.short_p(PROBE_MONO_SHORT),
		.long_p(PROBE_MONO_LONG)
	);

	// ****************************************
	// ahb-lite registers
	// ****************************************
	logic wr_pend_r;
	logic [7:0] wr_ofs_r;
	logic [IRQ_W-1:0] istat_r;
	logic [IRQ_W-1:0] imask_r;
	logic [31:0] rd_word;

	wire ap = HSEL & HTRANS[1] & HREADY;
	wire in_map = HADDR[31:8] == 24'h000000;
	wire wr_ctrl = wr_pend_r && wr_ofs_r == CTRL_OFS;
	wire wr_istat = wr_pend_r && wr_ofs_r == ISTAT_OFS;
	wire wr_imask = wr_pend_r && wr_ofs_r == IMASK_OFS;
	wire [IRQ_W-1:0] ev = {done_ev, full_v & ~full_r};
	wire [IRQ_W-1:0] w1c = wr_istat ? HWDATA[IRQ_W-1:0] : '0;
	wire [IRQ_W-1:0] istat_nxt = (istat_r & ~w1c) | ev;
	wire [IRQ_W-1:0] imask_nxt = wr_imask ? HWDATA[IRQ_W-1:0] : imask_r;

	assign rd_word = !in_map ? 32'h0000_0000
		: HADDR[7:0] == CTRL_OFS ? {31'h0, run_r}
		: HADDR[7:0] == STAT_OFS ? {26'h0, ONWARD_READ_ENABLE, HIT_FORCE_CTL,
			full_r}
		: HADDR[7:0] == ISTAT_OFS ? {27'h0, istat_r}
		: HADDR[7:0] == IMASK_OFS ? {27'h0, imask_r}
		: 32'h0000_0000;

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			wr_pend_r <= 1'b0;
			wr_ofs_r <= 8'h00;
			HRDATA <= 32'h0000_0000;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end else begin
			wr_pend_r <= ap & HWRITE & in_map;
			wr_ofs_r <= ap ? HADDR[7:0] : wr_ofs_r;
			HRDATA <= (ap & ~HWRITE) ? rd_word : 32'h0000_0000;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			run_r <= CTRL_RUN_RST;
			init_r <= 1'b0;
			istat_r <= IRQ_RST;
			imask_r <= IRQ_RST;
			IRQ <= 1'b0;
		end else begin
			run_r <= wr_ctrl ? HWDATA[CTRL_RUN_BIT] : run_r;
			init_r <= wr_ctrl & HWDATA[CTRL_INIT_BIT];
			istat_r <= istat_nxt;
			imask_r <= imask_nxt;
			IRQ <= |(istat_nxt & imask_nxt);
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);

	a_flag_follows_full: assert property (
		full_v[0] |=> FULL_FLAG_VARIANT_ONE)
		else $error("variant one flag missed a full row");
	a_flag_is_or: assert property (
		FULL_FLAG_VARIANT_FOUR == $past(|full_a[3*NROWS+:NROWS]))
		else $error("variant four flag is not the row OR");
	a_bank_gray: assert property (
		rif.step && $past(rif.step)
		|-> $countones(rif.bank ^ $past(rif.bank)) == 1)
		else $error("bank select moved more than one bit");
	a_seven_steps: assert property (disable iff (!RST_B || !run_r)
		run_r && bx_cnt_r == 4'h0 && $past(bx_last)
		|-> rif.step [*7] ##1 !rif.step)
		else $error("crossing did not interrogate seven banks");
	a_onward_end: assert property (
		done_ev |=> ONWARD_READ_ENABLE && !RD_VALID)
		else $error("onward flag missing at column end");
	a_probe_copy: assert property (
		##1 PROBE_BANK_SEL_BIT0 == $past(rif.bank[0])
		&& PROBE_ROW_RESET == $past(init_r))
		else $error("probe copy out of step");
	a_irq_level: assert property (
		IRQ == |(istat_r & imask_r))
		else $error("interrupt not matching masked status");

	c_flag_rise: cover property ($rose(FULL_FLAG_VARIANT_ONE));
	c_read_word: cover property (RD_VALID ##1 RD_VALID);
	c_read_done: cover property ($rose(ONWARD_READ_ENABLE));
	c_irq: cover property ($rose(IRQ));
endmodule : hit_test_top

/* tb/seq_model.sv */
`timescale 1ns/1ps
module seq_model #(
	parameter int HW = 64,
	parameter int DW = 10,
	parameter int PW = 4
) (
	// clock
	input wire logic clk,
	// readout return
	input wire logic rd_valid,
	input wire logic [DW-1:0] rd_data,
	input wire logic onward,
	// control pins
	output logic [HW-1:0] pix_hit,
	output logic force_ctl,
	output logic stim,
	output logic ext_rst,
	output logic read_en,
	output logic [1:0] col_sel
);
	initial begin
		pix_hit = '0;
		force_ctl = 1'b0;
		stim = 1'b0;
		ext_rst = 1'b0;
		read_en = 1'b0;
		col_sel = 2'h0;
	end

	task automatic set_hits(input logic f, input logic [HW-1:0] p);
		force_ctl <= f;
		pix_hit <= p;
	endtask : set_hits

	// ext_rst is pulsed for one cycle before every stimulus
	task automatic fire();
		ext_rst <= 1'b1;
		@(posedge clk);
		ext_rst <= 1'b0;
		stim <= 1'b1;
		@(posedge clk);
		stim <= 1'b0;
	endtask : fire

	// words, rows seen, most words of one row, bad patterns
	task automatic read_col(input logic [1:0] c, input logic [PW-1:0] ep,
		output int n, output int nr, output int mx, output int pb);
		int cnt[8] = '{default: 0};
		n = 0;
		nr = 0;
		mx = 0;
		pb = 0;
		read_en <= 1'b1;
		col_sel <= c;
		for (int k = 0; k < 300 && onward !== 1'b1; k++) begin
			@(posedge clk);
			#1;
			if (rd_valid === 1'b1) begin
				n++;
				cnt[rd_data[DW-1-:3]]++;
				if (rd_data[PW-1:0] !== ep) pb++;
			end
		end
		@(posedge clk);
		read_en <= 1'b0;
		repeat (2) @(posedge clk);
		foreach (cnt[i]) begin
			if (cnt[i] != 0) nr++;
			if (cnt[i] > mx) mx = cnt[i];
		end
	endtask : read_col
endmodule : seq_model

/* tb/hit_override_overflow_test_tb.sv */
`timescale 1ns/1ps
module hit_override_overflow_test_tb;
	import hof_pkg::*;
	localparam int NR = 4;
	typedef struct {logic [7:0] a; logic w; logic [31:0] d, e;} row_s;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, r;
	logic hreadyout, irq, rd_valid, onward, ff1, ff2, ff3, ff4, hresp;
	logic p_bank, p_rst, p_ph1, p_ph2, p_ph3, m_s, m_l;
	logic force_ctl, stim, read_en;
	logic [63:0] pix_hit;
	logic [9:0] rd_data;
	logic [1:0] col_sel;
	int n_mismatch = 0;
	int num_checks = 0;
	int n, nr, mx, pb;
	int cw[7];
	row_s rows[10] = '{'{CTRL_OFS, 1'b0, 32'h0, 32'h0},
		'{IMASK_OFS, 1'b0, 32'h0, 32'h0}, '{ISTAT_OFS, 1'b0, 32'h0, 32'h0},
		'{STAT_OFS, 1'b0, 32'h0, 32'h0}, '{IMASK_OFS, 1'b1, 32'hF, 32'hF},
		'{CTRL_OFS, 1'b1, 32'h1, 32'h1}, '{CTRL_OFS, 1'b1, 32'h0, 32'h0},
		'{CTRL_OFS, 1'b1, 32'h2, 32'h0}, '{STAT_OFS, 1'b1, 32'hFF, 32'h0},
		'{8'h40, 1'b1, 32'h5, 32'h0}};

	always #10 clk_sys = ~clk_sys;

	hit_test_top #(.NROWS(NR), .PW(4)) dut_u (.CLK_SYS(clk_sys),
		.RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
		.HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp), .IRQ(irq),
		.PIX_HIT(pix_hit), .HIT_FORCE_CTL(force_ctl), .READ_EN(read_en),
		.COL_SEL(col_sel), .RD_VALID(rd_valid), .RD_DATA(rd_data),
		.ONWARD_READ_ENABLE(onward), .FULL_FLAG_VARIANT_ONE(ff1),
		.FULL_FLAG_VARIANT_TWO(ff2), .FULL_FLAG_VARIANT_THREE(ff3),
		.FULL_FLAG_VARIANT_FOUR(ff4), .PROBE_BANK_SEL_BIT0(p_bank),
		.PROBE_ROW_RESET(p_rst), .PROBE_PHASE_ONE(p_ph1),
		.PROBE_PHASE_TWO(p_ph2), .PROBE_PHASE_THREE(p_ph3),
		.TEST_HIT_STIMULUS(stim), .PROBE_MONO_SHORT(m_s),
		.PROBE_MONO_LONG(m_l));

	seq_model #(.HW(64), .DW(10), .PW(4)) seq_u (.clk(clk_sys),
		.rd_valid(rd_valid), .rd_data(rd_data), .onward(onward),
		.pix_hit(pix_hit), .force_ctl(force_ctl), .stim(stim), .ext_rst(),
		.read_en(read_en), .col_sel(col_sel));

	// ****
	// helpers
	// ****
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		if (g !== e) begin
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
			n_mismatch++;
		end
		num_checks++;
	endtask : chk

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test

	// single word transfer, entered just after a rising edge
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		r = hrdata;
	endtask : bus

	// counts probe activity over c cycles
	task automatic watch(input int c);
		logic lb;
		lb = p_bank;
		cw = '{default: 0};
		repeat (c) begin
			#1;
			cw[0] += p_ph1;
			cw[1] += p_ph2;
			cw[2] += p_ph3;
			cw[3] += p_rst;
			cw[4] += m_s;
			cw[5] += m_l;
			cw[6] += (p_bank !== lb);
			lb = p_bank;
			@(posedge clk_sys);
		end
		@(posedge clk_sys);
	endtask : watch

	task automatic col(input logic [1:0] c, input logic [3:0] ep,
		input int en, input int enr, input int emx);
		seq_u.read_col(c, ep, n, nr, mx, pb);
		chk(n, en);
		chk(nr, enr);
		chk(mx, emx);
		chk(pb, 0);
	endtask : col

	// ****
	// sequence
	// ****
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		finish_test();
	end

	initial begin
		repeat (6) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		foreach (rows[i]) begin
			if (rows[i].w) bus(rows[i].a, 1'b1, rows[i].d);
			bus(rows[i].a, 1'b0, 32'h0);
			chk(r, rows[i].e);
		end
		$display("test registers done");
		seq_u.set_hits(1'b1, 64'h3333_2222_1111_0000);
		bus(CTRL_OFS, 1'b1, 32'h1);
		repeat (16) @(posedge clk_sys);
		chk({ff4, ff3, ff2, ff1}, 32'h0);
		repeat (16) @(posedge clk_sys);
		chk({ff4, ff3, ff2, ff1}, 32'hF);
		chk(irq, 32'h1);
		bus(ISTAT_OFS, 1'b0, 32'h0);
		chk(r, 32'hF);
		bus(ISTAT_OFS, 1'b1, 32'hF);
		bus(ISTAT_OFS, 1'b0, 32'h0);
		chk(r, 32'h0);
		chk(irq, 32'h0);
		repeat (24) @(posedge clk_sys);
		bus(CTRL_OFS, 1'b1, 32'h0);
		repeat (10) @(posedge clk_sys);
		for (int c = 0; c < 4; c++) begin
			col(c[1:0], c[3:0], NR * MEM_DEPTH, NR, MEM_DEPTH);
		end
		bus(ISTAT_OFS, 1'b0, 32'h0);
		chk(r[IRQ_DONE_BIT], 32'h1);
		$display("test forced fill done");
		bus(CTRL_OFS, 1'b1, 32'h2);
		watch(4);
		chk(cw[3], 32'h1);
		chk({ff4, ff3, ff2, ff1}, 32'h0);
		seq_u.set_hits(1'b0, 64'h1_0000);
		bus(CTRL_OFS, 1'b1, 32'h1);
		repeat (10) @(posedge clk_sys);
		watch(16);
		chk(cw[0], 32'hE);
		chk(cw[1], 32'hE);
		chk(cw[2], 32'h2);
		chk(cw[6] != 0, 32'h1);
		chk(cw[6], 32'h8);
		repeat (16) @(posedge clk_sys);
		chk({ff4, ff3, ff2, ff1}, 32'h2);
		bus(CTRL_OFS, 1'b1, 32'h0);
		repeat (10) @(posedge clk_sys);
		col(2'h1, 4'h1, MEM_DEPTH, 1, MEM_DEPTH);
		col(2'h0, 4'h0, 0, 0, 0);
		$display("test normal hits done");
		seq_u.fire();
		watch(40);
		chk(cw[4], MONO_SHORT_CYC);
		chk(cw[5], MONO_LONG_CYC);
		$display("test monostable done");
		seq_u.set_hits(1'b1, 64'h0);
		bus(CTRL_OFS, 1'b1, 32'h1);
		repeat (40) @(posedge clk_sys);
		chk({ff4, ff3, ff2, ff1}, 32'hF);
		bus(CTRL_OFS, 1'b1, 32'h0);
		repeat (10) @(posedge clk_sys);
		col(2'h3, 4'h0, NR * MEM_DEPTH, NR, MEM_DEPTH);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		chk({irq, ff4, ff3, ff2, ff1}, 32'h0);
		chk(hresp, 32'h0);
		bus(STAT_OFS, 1'b0, 32'h0);
		chk(r, 32'h1 << STAT_FORCE_BIT);
		$display("test reset done");
		finish_test();
	end
endmodule : hit_override_overflow_test_tb
